//--- inc/udt_defines.svh
// Purpose: constants of the up/down capture/reload timer
// Assumes: included by the package and the design file
// Notes:   definitions only
`ifndef UDT_DEFINES_SVH
`define UDT_DEFINES_SVH

// --------------------------------------------------------------
// instances and widths
// --------------------------------------------------------------
`define UDT_NUM_TIMERS 3
`define UDT_COUNT_W 16

// --------------------------------------------------------------
// clock select field encodings
// --------------------------------------------------------------
`define UDT_CSEL_DIV12 2'h0
`define UDT_CSEL_DIV1 2'h1
`define UDT_CSEL_DIV2 2'h2
`define UDT_CSEL_EXT8 2'h3

// --------------------------------------------------------------
// prescaler terminal counts
// --------------------------------------------------------------
`define UDT_DIV12_LAST 4'hb
`define UDT_EXT8_LAST 3'h7

// --------------------------------------------------------------
// software write data bit positions
// --------------------------------------------------------------
`define UDT_OVF_FLAG_BIT 7
`define UDT_EXT_FLAG_BIT 6
`define UDT_TOGGLE_BIT 2

// --------------------------------------------------------------
// count values and reset values
// --------------------------------------------------------------
`define UDT_COUNT_MAX 16'hffff
`define UDT_COUNT_MIN 16'h0000
`define UDT_COUNT_RST 16'h0000
`define UDT_RELOAD_RST 16'h0000

`endif

//--- inc/udt_pkg.sv
// Purpose: types shared by the timer design and its bench
// Assumes: udt_defines.svh on the include path
// Notes:   field order of each struct is fixed, msb first
`include "udt_defines.svh"

package udt_pkg;

    // control bits written by software
    typedef struct packed {
        logic capture_reload_select;
        logic counter_timer_select;
        logic run_control;
        logic external_enable;
    } udt_ctrl_t;

    // configuration bits written by software
    typedef struct packed {
        logic [1:0] clock_select;
        logic decrement_enable;
        logic output_enable;
    } udt_cfg_t;

    // one-cycle software write strobes with their byte
    typedef struct packed {
        logic count_low_wr;
        logic count_high_wr;
        logic reload_low_wr;
        logic reload_high_wr;
        logic flag_wr;
        logic toggle_wr;
        logic [7:0] data;
    } udt_sw_t;

    // state visible to software
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capture_reload;
        logic overflow_underflow_flag;
        logic external_flag;
        logic toggle_state;
    } udt_stat_t;

endpackage

//--- rtl/udt_top.sv
// Purpose: three identical 16-bit up/down capture/reload/toggle timers
// Assumes: pins synchronous to sys_clk_in, software bits held as levels
// Notes:   no register bus; control bits and write strobes are ports
`timescale 1ns/100ps
`include "udt_defines.svh"

// --------------------------------------------------------------
// one timer channel
// --------------------------------------------------------------
module udt_chan (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // software side
    input wire udt_pkg::udt_ctrl_t ctrl_in,
    input wire udt_pkg::udt_cfg_t cfg_in,
    input wire udt_pkg::udt_sw_t sw_in,
    // prescaled clock enables, one cycle each
    input wire logic [3:0] tick_in,
    // pins
    input wire logic count_input_pin_in,
    input wire logic trigger_direction_pin_in,
    // results
    output udt_pkg::udt_stat_t stat_out,
    output logic toggle_pin_out,
    output logic toggle_pin_oe_out
);
    import udt_pkg::*;

    logic [15:0] count_reg, count_next;
    logic [15:0] reload_reg, reload_next;
    logic ovf_reg, ovf_next;
    logic exf_reg, exf_next;
    logic tog_reg, tog_next;
    logic oe_reg;
    logic cnt_pin_reg, trig_pin_reg;
    logic cnt_fall, trig_fall, tick, up, trig_evt, wrap;

    // edge detect; pins are already in this clock domain
    assign cnt_fall = cnt_pin_reg & ~count_input_pin_in;
    assign trig_fall = trig_pin_reg & ~trigger_direction_pin_in;
    // pin edges or chosen clock; only while running
    assign tick = ctrl_in.run_control & (ctrl_in.counter_timer_select ?
                  cnt_fall : tick_in[cfg_in.clock_select]);
    assign up = cfg_in.decrement_enable ? trigger_direction_pin_in : 1'b1;
    // trigger edges act only without decrement and with enable
    assign trig_evt = trig_fall & ctrl_in.external_enable &
                      ~cfg_in.decrement_enable;
    // wrap point differs: reload mode down count ends at the reload pair
    always_comb begin
        wrap = 1'b0;
        if (tick) begin
            if (up) begin
                wrap = (count_reg == `UDT_COUNT_MAX);
            end else if (ctrl_in.capture_reload_select) begin
                wrap = (count_reg == `UDT_COUNT_MIN);
            end else begin
                wrap = (count_reg == reload_reg);
            end
        end
    end

    // next state of count, pair, flags and toggle
    always_comb begin
        count_next = count_reg;
        reload_next = reload_reg;
        ovf_next = ovf_reg;
        exf_next = exf_reg;
        tog_next = tog_reg;
        if (ctrl_in.capture_reload_select) begin
            // plain 16-bit wrap in capture mode
            if (tick) begin
                count_next = up ? count_reg + 16'h0001 :
                             count_reg - 16'h0001;
            end
            if (trig_evt) begin
                reload_next = count_reg;
            end
        end else begin
            if (wrap) begin
                count_next = up ? reload_reg : `UDT_COUNT_MAX;
            end else if (tick) begin
                count_next = up ? count_reg + 16'h0001 :
                             count_reg - 16'h0001;
            end
            if (trig_evt) begin
                count_next = reload_reg;
            end
        end
        // software byte writes win over counting
        if (sw_in.count_low_wr) begin
            count_next[7:0] = sw_in.data;
        end
        if (sw_in.count_high_wr) begin
            count_next[15:8] = sw_in.data;
        end
        if (sw_in.reload_low_wr) begin
            reload_next[7:0] = sw_in.data;
        end
        if (sw_in.reload_high_wr) begin
            reload_next[15:8] = sw_in.data;
        end
        // flags move only by software write or their events
        if (sw_in.flag_wr) begin
            ovf_next = sw_in.data[`UDT_OVF_FLAG_BIT];
            exf_next = sw_in.data[`UDT_EXT_FLAG_BIT];
        end
        // hardware set beats a same-cycle software clear
        if (wrap) begin
            ovf_next = 1'b1;
        end
        if (trig_evt && ctrl_in.capture_reload_select) begin
            exf_next = 1'b1;
        end
        // seventeenth count bit in reload mode, no interrupt
        if (wrap && !ctrl_in.capture_reload_select) begin
            exf_next = ~exf_next;
        end
        // forced level, then wrap still inverts it
        if (sw_in.toggle_wr) begin
            tog_next = sw_in.data[`UDT_TOGGLE_BIT];
        end
        if (wrap) begin
            tog_next = ~tog_next;
        end
    end

    // register stage
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            count_reg <= `UDT_COUNT_RST;
            reload_reg <= `UDT_RELOAD_RST;
            ovf_reg <= 1'b0;
            exf_reg <= 1'b0;
            tog_reg <= 1'b0;
            oe_reg <= 1'b0;
            cnt_pin_reg <= 1'b0;
            trig_pin_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            reload_reg <= reload_next;
            ovf_reg <= ovf_next;
            exf_reg <= exf_next;
            tog_reg <= tog_next;
            oe_reg <= cfg_in.output_enable;
            cnt_pin_reg <= count_input_pin_in;
            trig_pin_reg <= trigger_direction_pin_in;
        end
    end

    assign stat_out = '{count: count_reg, capture_reload: reload_reg,
                        overflow_underflow_flag: ovf_reg,
                        external_flag: exf_reg, toggle_state: tog_reg};
    assign toggle_pin_out = tog_reg;
    assign toggle_pin_oe_out = oe_reg;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    logic cnt_wr, rld_wr;
    assign cnt_wr = sw_in.count_low_wr | sw_in.count_high_wr;
    assign rld_wr = sw_in.reload_low_wr | sw_in.reload_high_wr;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    chk_cap_copy: assert property (
        ctrl_in.capture_reload_select && trig_evt && !rld_wr
        |=> reload_reg == $past(count_reg) && exf_reg)
        else $error("capture did not copy count or set flag");
    chk_cap_overflow: assert property (
        ctrl_in.capture_reload_select && tick && up && !cnt_wr &&
        count_reg == 16'hffff |=> count_reg == 16'h0000 && ovf_reg)
        else $error("capture overflow wrong");
    chk_cap_underflow: assert property (
        ctrl_in.capture_reload_select && tick && !up && !cnt_wr &&
        count_reg == 16'h0000 |=> count_reg == 16'hffff && ovf_reg)
        else $error("capture underflow wrong");
    chk_reload_up: assert property (
        !ctrl_in.capture_reload_select && tick && up && !trig_evt &&
        !cnt_wr && count_reg == 16'hffff
        |=> count_reg == $past(reload_reg) && ovf_reg)
        else $error("overflow reload wrong");
    chk_trig_reload: assert property (
        !ctrl_in.capture_reload_select && trig_evt && !cnt_wr
        |=> count_reg == $past(reload_reg))
        else $error("trigger reload missing");
    chk_reload_down: assert property (
        !ctrl_in.capture_reload_select && tick && !up && !cnt_wr &&
        !trig_evt && count_reg == reload_reg
        |=> count_reg == 16'hffff && ovf_reg)
        else $error("underflow reload wrong");
    chk_dir_only: assert property (
        cfg_in.decrement_enable && !sw_in.flag_wr && !wrap
        |=> $stable(exf_reg))
        else $error("trigger acted while decrementing");
    chk_exf_bit16: assert property (
        !ctrl_in.capture_reload_select && wrap && !sw_in.flag_wr
        |=> exf_reg != $past(exf_reg))
        else $error("external flag did not invert");
    chk_toggle_wrap: assert property (
        wrap && !sw_in.toggle_wr |=> tog_reg != $past(tog_reg)
        ##0 toggle_pin_out == tog_reg)
        else $error("toggle pin did not invert");
    chk_flag_sticky: assert property (
        ovf_reg && !sw_in.flag_wr |=> ovf_reg)
        else $error("overflow flag cleared by itself");
    chk_run_hold: assert property (
        !ctrl_in.run_control && !cnt_wr && !trig_evt |=> $stable(count_reg))
        else $error("count moved while stopped");
    cov_cap: cover property (ctrl_in.capture_reload_select && trig_evt);
    cov_up_wrap: cover property (!ctrl_in.capture_reload_select && wrap && up);
    cov_dn_wrap: cover property (!ctrl_in.capture_reload_select && wrap && !up);
    cov_two_toggles: cover property (wrap ##[1:300] wrap);
endmodule

// --------------------------------------------------------------
// top: shared prescaler and three channels
// --------------------------------------------------------------
module udt_top (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic ext_osc_in,
    // software side, one entry per timer
    input wire udt_pkg::udt_ctrl_t [2:0] ctrl_in,
    input wire udt_pkg::udt_cfg_t [2:0] cfg_in,
    input wire udt_pkg::udt_sw_t [2:0] sw_in,
    // pins
    input wire logic [2:0] count_input_pin_in,
    input wire logic [2:0] trigger_direction_pin_in,
    output logic [2:0] toggle_pin_out,
    output logic [2:0] toggle_pin_oe_out,
    // status
    output udt_pkg::udt_stat_t [2:0] stat_out
);
    import udt_pkg::*;

    logic [3:0] div12_reg, div12_next;
    logic div2_reg, div2_next;
    logic [2:0] ext_cnt_reg, ext_cnt_next;
    logic ext_prev_reg;
    logic ext_rise;
    logic [3:0] tick;

    // one enable pulse per rate, indexed by the clock select code
    assign ext_rise = ext_osc_in & ~ext_prev_reg;
    always_comb begin
        div12_next = (div12_reg == `UDT_DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
        div2_next = ~div2_reg;
        ext_cnt_next = ext_rise ? ext_cnt_reg + 3'h1 : ext_cnt_reg;
        tick = 4'h0;
        tick[`UDT_CSEL_DIV12] = (div12_reg == `UDT_DIV12_LAST);
        tick[`UDT_CSEL_DIV1] = 1'b1;
        tick[`UDT_CSEL_DIV2] = div2_reg;
        tick[`UDT_CSEL_EXT8] = ext_rise && (ext_cnt_reg == `UDT_EXT8_LAST);
    end

    // prescaler registers; the slow clock is sampled, not used as a clock
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            div12_reg <= 4'h0;
            div2_reg <= 1'b0;
            ext_cnt_reg <= 3'h0;
            ext_prev_reg <= 1'b0;
        end else begin
            div12_reg <= div12_next;
            div2_reg <= div2_next;
            ext_cnt_reg <= ext_cnt_next;
            ext_prev_reg <= ext_osc_in;
        end
    end

    for (genvar i = 0; i < `UDT_NUM_TIMERS; i++) begin : g_tmr
        udt_chan u_chan (
            .sys_clk_in(sys_clk_in),
            .rst_in(rst_in),
            .ctrl_in(ctrl_in[i]),
            .cfg_in(cfg_in[i]),
            .sw_in(sw_in[i]),
            .tick_in(tick),
            .count_input_pin_in(count_input_pin_in[i]),
            .trigger_direction_pin_in(trigger_direction_pin_in[i]),
            .stat_out(stat_out[i]),
            .toggle_pin_out(toggle_pin_out[i]),
            .toggle_pin_oe_out(toggle_pin_oe_out[i])
        );
    end
endmodule

//--- test/udt_pin_model.sv
// Purpose: pin-side partner of the three timers
// Assumes: bench sets pin levels just after a rising clock edge
// Notes:   external oscillator runs free, period of four system clocks
`timescale 1ns/100ps

// --------------------------------------------------------------
// pin model
// --------------------------------------------------------------
module udt_pin_model (
    // clock
    input wire logic sys_clk_in,
    // requested pin levels from the bench
    input wire logic [2:0] count_level_in,
    input wire logic [2:0] trig_level_in,
    // pins toward the timers
    output logic [2:0] count_input_pin_out,
    output logic [2:0] trigger_direction_pin_out,
    output logic ext_osc_out
);
    logic [1:0] osc_div_reg = 2'h0;

    // pins move one clock after the request, like a synchronised board
    // signal, so no edge ever lands between two system clocks
    always @(posedge sys_clk_in) begin
        count_input_pin_out <= count_level_in;
        trigger_direction_pin_out <= trig_level_in;
        osc_div_reg <= osc_div_reg + 2'h1;
    end

    // oscillator keeps running whatever the timers do
    assign ext_osc_out = osc_div_reg[1];
endmodule

//--- test/updown_capture_reload_timer_tb_top.sv
// Purpose: scenario bench for the three up/down timers
// Assumes: pins driven through udt_pin_model, counts use pin pulses except in t_rate
// Notes:   prescaler phase is free, so rate checks allow one count slack
`timescale 1ns/100ps

// --------------------------------------------------------------
// bench top
// --------------------------------------------------------------
module updown_capture_reload_timer_tb_top;
    import udt_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    udt_ctrl_t [2:0] ctrl_in = '0;
    udt_cfg_t [2:0] cfg_in = '0;
    udt_sw_t [2:0] sw_in = '0;
    logic [2:0] cnt_lvl = 3'h0;
    logic [2:0] trig_lvl = 3'h0;
    logic [2:0] cnt_pin;
    logic [2:0] trig_pin;
    logic [2:0] tgl_pin;
    logic [2:0] tgl_oe;
    logic ext_osc;
    udt_stat_t [2:0] stat;
    int errors = 0;
    int samples_checked = 0;

    // 25 MHz system clock
    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    udt_top dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .ext_osc_in(ext_osc), .ctrl_in(ctrl_in), .cfg_in(cfg_in),
        .sw_in(sw_in), .count_input_pin_in(cnt_pin),
        .trigger_direction_pin_in(trig_pin), .toggle_pin_out(tgl_pin),
        .toggle_pin_oe_out(tgl_oe), .stat_out(stat));

    udt_pin_model pin_u (.sys_clk_in(sys_clk_in),
        .count_level_in(cnt_lvl), .trig_level_in(trig_lvl),
        .count_input_pin_out(cnt_pin),
        .trigger_direction_pin_out(trig_pin), .ext_osc_out(ext_osc));

    // --------------------------------------------------------------
    // compare and drive helpers
    // --------------------------------------------------------------
    task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(string nm, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    // rate checks accept one count either side for prescaler phase
    task automatic chk_near(string nm, int e, logic [15:0] g);
        samples_checked++;
        if ($isunknown(g) || int'(g) < e - 1 || int'(g) > e + 1) begin
            errors++;
            $display("BAD %s expected %0d seen %h", nm, e, g);
        end
    endtask

    // ends a bit after the edge so design updates have landed
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // kind: 0/1 count lo/hi, 2/3 reload lo/hi, 4 flags, 5 toggle
    task automatic sw(int ch, int kind, logic [7:0] d);
        udt_sw_t s;
        s = '0;
        s.data = d;
        s.count_low_wr = (kind == 0);
        s.count_high_wr = (kind == 1);
        s.reload_low_wr = (kind == 2);
        s.reload_high_wr = (kind == 3);
        s.flag_wr = (kind == 4);
        s.toggle_wr = (kind == 5);
        @(posedge sys_clk_in);
        sw_in[ch] <= s;
        @(posedge sys_clk_in);
        sw_in[ch] <= '0;
        cyc(1);
    endtask

    task automatic wr16(int ch, int kind, logic [15:0] v);
        sw(ch, kind, v[7:0]);
        sw(ch, kind + 1, v[15:8]);
    endtask

    // c = {capture, counter, run, ext}; f = {select[1:0], dec, oe}
    task automatic setup(int ch, logic [3:0] c, logic [3:0] f);
        @(posedge sys_clk_in);
        ctrl_in[ch] <= c;
        cfg_in[ch] <= f;
        cyc(2);
    endtask

    // one falling edge on the count pin, pin seen high first
    task automatic pulse(int ch);
        @(posedge sys_clk_in);
        cnt_lvl[ch] <= 1'b1;
        cyc(3);
        @(posedge sys_clk_in);
        cnt_lvl[ch] <= 1'b0;
        cyc(4);
    endtask

    task automatic trig(int ch, logic v);
        @(posedge sys_clk_in);
        trig_lvl[ch] <= v;
        cyc(4);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_capture();
        wr16(0, 0, 16'h1234);
        wr16(0, 2, 16'hcdab);
        chk_word("count", 16'h1234, stat[0].count);
        chk_word("reload", 16'hcdab, stat[0].capture_reload);
        setup(0, 4'b1100, 4'h0);
        pulse(0);
        chk_word("count", 16'h1234, stat[0].count);
        trig(0, 1'b1);
        trig(0, 1'b0);
        chk_word("reload", 16'hcdab, stat[0].capture_reload);
        chk_bit("ext_flag", 1'b0, stat[0].external_flag);
        setup(0, 4'b1101, 4'h0);
        trig(0, 1'b1);
        trig(0, 1'b0);
        chk_word("reload", 16'h1234, stat[0].capture_reload);
        chk_bit("ext_flag", 1'b1, stat[0].external_flag);
        wr16(0, 0, 16'hffff);
        setup(0, 4'b1110, 4'h0);
        pulse(0);
        chk_word("count", 16'h0000, stat[0].count);
        chk_bit("ovf_flag", 1'b1, stat[0].overflow_underflow_flag);
        chk_bit("toggle", 1'b1, stat[0].toggle_state);
        pulse(0);
        chk_word("count", 16'h0001, stat[0].count);
        chk_word("other_count", 16'h0000, stat[1].count);
        cyc(50);
        chk_bit("ovf_flag", 1'b1, stat[0].overflow_underflow_flag);
        chk_bit("ext_flag", 1'b1, stat[0].external_flag);
        sw(0, 4, 8'h00);
        chk_bit("ovf_flag", 1'b0, stat[0].overflow_underflow_flag);
    endtask

    task automatic t_down();
        setup(1, 4'b1111, 4'b0010);
        trig(1, 1'b1);
        trig(1, 1'b0);
        chk_bit("ext_flag", 1'b0, stat[1].external_flag);
        pulse(1);
        chk_word("count", 16'hffff, stat[1].count);
        chk_bit("ovf_flag", 1'b1, stat[1].overflow_underflow_flag);
        trig(1, 1'b1);
        pulse(1);
        chk_word("count", 16'h0000, stat[1].count);
    endtask

    task automatic t_reload();
        wr16(2, 2, 16'h1000);
        wr16(2, 0, 16'hffff);
        setup(2, 4'b0111, 4'h0);
        trig(2, 1'b1);
        pulse(2);
        chk_word("count", 16'h1000, stat[2].count);
        chk_bit("ovf_flag", 1'b1, stat[2].overflow_underflow_flag);
        chk_bit("ext_flag", 1'b1, stat[2].external_flag);
        pulse(2);
        chk_word("count", 16'h1001, stat[2].count);
        trig(2, 1'b0);
        chk_word("count", 16'h1000, stat[2].count);
        sw(2, 4, 8'h40);
        setup(2, 4'b0111, 4'b0010);
        wr16(2, 0, 16'h1002);
        pulse(2);
        pulse(2);
        chk_word("count", 16'h1000, stat[2].count);
        chk_bit("ovf_flag", 1'b0, stat[2].overflow_underflow_flag);
        pulse(2);
        chk_word("count", 16'hffff, stat[2].count);
        chk_bit("ovf_flag", 1'b1, stat[2].overflow_underflow_flag);
        chk_bit("ext_flag", 1'b0, stat[2].external_flag);
        sw(2, 5, 8'h04);
        chk_bit("toggle_pin", 1'b1, tgl_pin[2]);
        sw(2, 5, 8'h00);
        chk_bit("toggle", 1'b0, stat[2].toggle_state);
        setup(2, 4'b0000, 4'b0001);
        chk_bit("toggle_oe", 1'b1, tgl_oe[2]);
        chk_bit("other_oe", 1'b0, tgl_oe[0]);
    endtask

    task automatic t_rate();
        logic [1:0] sel [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
        int n [4] = '{48, 48, 48, 128};
        int e [4] = '{48, 24, 4, 4};
        for (int i = 0; i < 4; i++) begin
            setup(1, 4'b1000, {sel[i], 2'b00});
            wr16(1, 0, 16'h0000);
            @(posedge sys_clk_in);
            ctrl_in[1] <= 4'b1010;
            repeat (n[i]) @(posedge sys_clk_in);
            ctrl_in[1] <= 4'b1000;
            cyc(3);
            chk_near("rate_count", e[i], stat[1].count);
        end
    endtask

    // --------------------------------------------------------------
    // verdict, watchdog and main sequence
    // --------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // whole run is about 600 clocks; allow more than ten times that
    initial begin
        #400000;
        errors++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        cyc(2);
        for (int c = 0; c < 3; c++) begin
            chk_word("reset_count", 16'h0000, stat[c].count);
        end
        t_capture();
        t_down();
        t_reload();
        t_rate();
        summarize();
    end
endmodule
